// file: design/gmpc_defines.vh
/*
 * Constants for the pin function control block: register indices, control
 * bit positions, modem pin positions within a nibble and the soft reset time.
 * Assumes it is included by bare name from every design file of the block.
 */
`ifndef GMPC_DEFINES_VH
`define GMPC_DEFINES_VH

// Register indices on the local register port
`define GMPC_ADDR_W 2
`define GMPC_ADDR_DIR 2'h0
`define GMPC_ADDR_STATE 2'h1
`define GMPC_ADDR_INTEN 2'h2
`define GMPC_ADDR_CTRL 2'h3

// Reset values
`define GMPC_RST_BYTE 8'h00
`define GMPC_RST_NIB 4'h0
`define GMPC_RST_STAT 3'h0

// pin_function_control bit positions
`define GMPC_CTRL_LATCH 0
`define GMPC_CTRL_MODEM_A 1
`define GMPC_CTRL_MODEM_B 2
`define GMPC_CTRL_SOFT_RESET_BIT 3
`define GMPC_CTRL_KEEP_MSB 2

// Modem pin positions inside a nibble
`define GMPC_NIB_DSR 0
`define GMPC_NIB_DTR 1
`define GMPC_NIB_CD 2
`define GMPC_NIB_RI 3

// Soft reset hold time and its cycle count at the system clock
`define GMPC_CLK_NS 10
`define GMPC_SRST_NS 40
`define GMPC_SRST_CYCLES ((`GMPC_SRST_NS + `GMPC_CLK_NS - 1) / `GMPC_CLK_NS)
`define GMPC_SRST_CNT_W 3

`endif

// file: design/gmpc_input_events.v
/*
 * Input change detection for the eight pins, with optional latching of the
 * level that caused the change. Pending is combinational; the parent
 * registers it. Assumes pin levels are synchronous to the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gmpc_defines.vh"

module gmpc_input_events (
   input wire clk_sys,
   input wire rst_b,
   input wire clear,
   input wire [7:0] pinLevel,
   input wire [7:0] armMask,
   input wire latchEnable,
   input wire readStrobe,
   output wire [7:0] stateView,
   output wire pending
);

   reg [7:0] refLevel;
   reg [7:0] captured;
   reg [7:0] latchedVal;

   wire [7:0] delta;
   wire [7:0] newCap;

   // Difference from the level seen at the last read, armed pins only
   assign delta = (pinLevel ^ refLevel) & armMask;
   assign newCap = delta & ~captured & {8{latchEnable}};

   // Unlatched: pending follows the live difference, so it drops back
   // Latched: pending sticks on the captured bits
   assign pending = latchEnable ? (|captured) : (|delta);

   // Captured bits show the level that caused the change
   assign stateView = (captured & latchedVal) | (~captured & pinLevel);

   // Unarmed pins track the pad so enabling one later raises nothing stale
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         refLevel <= `GMPC_RST_BYTE;
         captured <= `GMPC_RST_BYTE;
         latchedVal <= `GMPC_RST_BYTE;
      end else if (clear) begin
         refLevel <= pinLevel;
         captured <= `GMPC_RST_BYTE;
         latchedVal <= `GMPC_RST_BYTE;
      end else begin
         if (readStrobe) begin
            refLevel <= pinLevel;
         end else begin
            refLevel <= (refLevel & armMask) | (pinLevel & ~armMask);
         end
         if (!latchEnable) begin
            captured <= `GMPC_RST_BYTE;
         end else if (readStrobe) begin
            captured <= newCap;  // A change in the read cycle is kept
         end else begin
            captured <= captured | newCap;
         end
         latchedVal <= (newCap & pinLevel) | (~newCap & latchedVal);
      end
   end

endmodule // gmpc_input_events
`default_nettype wire

// file: design/gmpc_pin_control.v
/*
 * Pin function control for eight general-purpose pins: register file,
 * per-nibble choice between plain I/O and emulated modem lines, input change
 * interrupt and the self-clearing soft reset.
 * Assumes a local register port driven by the host interface logic, pad
 * levels synchronous to clk_sys, and that the UART channels take the modem
 * status, change and interrupt outputs and drive the terminal-ready and
 * modem interrupt enable inputs.
 * The soft reset clears only the registers held here; softReset carries it
 * on to the rest of the device.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gmpc_defines.vh"

// Functional notes
// - Writing one to the soft reset bit resets the whole device.
// - The soft reset bit clears itself once the reset has completed.
// - Control bit 2: low nibble plain I/O, or channel B modem lines.
// - Control bit 1: high nibble plain I/O, or channel A modem lines.
// - Unlatched: any input change interrupts; reading pin state clears it.
// - Unlatched: input returning before the read withdraws the interrupt.
// - Latched: change interrupts and captures the level; read clears it.
// - Latched: return before read keeps interrupt and the captured level.
// - Plain I/O nibble: its modem input pins do not show in modem status.
// - Plain I/O nibble: its pins never raise a modem status interrupt.
// - Plain I/O nibble: terminal-ready control bit does not drive the pin.
// - Modem nibble: its carrier, ring and set-ready levels show in status.
// - Modem nibble: terminal-ready pin follows the terminal-ready control bit.
// - Modem nibble with interrupt enable: a level change raises modem interrupt.
// - Modem nibble: direction, state and interrupt enable registers have no effect.
// - I/O input change interrupts only when its interrupt enable bit is one.
// - Direction bit zero makes the pin an input, one an output.
module gmpc_pin_control (
   input wire clk_sys,
   input wire rst_b,
   input wire [`GMPC_ADDR_W-1:0] regAddr,
   input wire regWrite,
   input wire regRead,
   input wire [7:0] regWdata,
   output reg [7:0] regRdata,
   input wire [7:0] gpioIn,
   output reg [7:0] gpioOut,
   output reg [7:0] gpioOe,
   input wire mcrTerminalReadyA,
   input wire mcrTerminalReadyB,
   input wire ierModemIntEnableA,
   input wire ierModemIntEnableB,
   output reg [2:0] modemStatusA,
   output reg [2:0] modemStatusB,
   output reg [2:0] modemChangeA,
   output reg [2:0] modemChangeB,
   output reg modemIrqA,
   output reg modemIrqB,
   output reg ioIrq,
   output reg softReset
);

   // Output enable of one nibble: only terminal ready drives in modem mode
   function [3:0] nibbleOe;
      input modem;
      input [3:0] dir;
      begin
         if (modem) begin
            nibbleOe = 4'h1 << `GMPC_NIB_DTR;
         end else begin
            nibbleOe = dir;
         end
      end
   endfunction

   // Output level of one nibble; the terminal-ready pin is active low
   function [3:0] nibbleOut;
      input modem;
      input [3:0] state;
      input dtr;
      begin
         if (modem) begin
            nibbleOut = (~dtr) ? (4'h1 << `GMPC_NIB_DTR) : 4'h0;
         end else begin
            nibbleOut = state;
         end
      end
   endfunction

   // Modem status bits {carrier, ring, set ready}, active high as seen
   // by the channel; pins are active low, plain I/O shows nothing
   function [2:0] nibbleStatus;
      input modem;
      input [3:0] pins;
      begin
         if (modem) begin
            nibbleStatus = {~pins[`GMPC_NIB_CD], ~pins[`GMPC_NIB_RI],
                            ~pins[`GMPC_NIB_DSR]};
         end else begin
            nibbleStatus = `GMPC_RST_STAT;
         end
      end
   endfunction

   // Register index match; the strobe decodes share it so an index
   // change touches one place only
   function hitAddr;
      input [`GMPC_ADDR_W-1:0] addr;
      input [`GMPC_ADDR_W-1:0] target;
      begin
         hitAddr = (addr == target);
      end
   endfunction

   reg [7:0] pinDirection;
   reg [7:0] pinState;
   reg [7:0] pinIntEnable;
   reg [`GMPC_CTRL_KEEP_MSB:0] ctrlBits;
   reg modemWasA;
   reg modemWasB;

   wire softResetBusy;
   wire modemA;
   wire modemB;
   wire latchOn;
   wire [7:0] modemMask;
   wire [7:0] ioArm;
   wire [7:0] stateView;
   wire ioPending;
   wire stateRead;
   wire ctrlWrite;
   wire resetStart;
   wire [7:0] ctrlView;
   wire [2:0] next_statusA;
   wire [2:0] next_statusB;
   wire [2:0] next_changeA;
   wire [2:0] next_changeB;
   wire [7:0] next_gpioOut;
   wire [7:0] next_gpioOe;
   wire next_modemIrqA;
   wire next_modemIrqB;
   wire next_ioIrq;
   wire writeOpen;

   assign modemA = ctrlBits[`GMPC_CTRL_MODEM_A];
   assign modemB = ctrlBits[`GMPC_CTRL_MODEM_B];
   assign latchOn = ctrlBits[`GMPC_CTRL_LATCH];
   assign modemMask = {{4{modemA}}, {4{modemB}}};

   // Armed pins: enabled, inputs, and not taken over by a modem nibble
   assign ioArm = pinIntEnable & ~pinDirection & ~modemMask;

   assign stateRead = regRead && hitAddr(regAddr, `GMPC_ADDR_STATE);
   assign ctrlWrite = regWrite && hitAddr(regAddr, `GMPC_ADDR_CTRL);
   assign resetStart = ctrlWrite && regWdata[`GMPC_CTRL_SOFT_RESET_BIT];

   // Reserved upper bits read as zero; reset bit reads one while busy
   assign ctrlView = {4'h0, softResetBusy, ctrlBits};

   assign next_gpioOe = {nibbleOe(modemA, pinDirection[7:4]),
                         nibbleOe(modemB, pinDirection[3:0])};
   assign next_gpioOut = {nibbleOut(modemA, pinState[7:4], mcrTerminalReadyA),
                          nibbleOut(modemB, pinState[3:0], mcrTerminalReadyB)};

   assign next_statusA = nibbleStatus(modemA, gpioIn[7:4]);
   assign next_statusB = nibbleStatus(modemB, gpioIn[3:0]);

   // Changes count only when the nibble was modem in both cycles, so a
   // mode switch itself never fakes a modem line change
   assign next_changeA = (next_statusA ^ modemStatusA) & {3{modemA & modemWasA}};
   assign next_changeB = (next_statusB ^ modemStatusB) & {3{modemB & modemWasB}};

   // Interrupt requests ahead of their output flops
   assign next_modemIrqA = (|next_changeA) & ierModemIntEnableA;
   assign next_modemIrqB = (|next_changeB) & ierModemIntEnableB;

   // The soft reset masks the pin interrupt so no stale request leaks out
   assign next_ioIrq = ioPending & ~softResetBusy;

   // Writes are refused while the soft reset holds the registers
   assign writeOpen = regWrite & ~softResetBusy;

   gmpc_soft_reset u_soft_reset (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .start(resetStart),
      .resetActive(softResetBusy)
   );

   gmpc_input_events u_input_events (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .clear(softResetBusy),
      .pinLevel(gpioIn),
      .armMask(ioArm),
      .latchEnable(latchOn),
      .readStrobe(stateRead),
      .stateView(stateView),
      .pending(ioPending)
   );

   // Register writes; the soft reset returns every register to reset value
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pinDirection <= `GMPC_RST_BYTE;
         pinState <= `GMPC_RST_BYTE;
         pinIntEnable <= `GMPC_RST_BYTE;
         ctrlBits <= `GMPC_RST_STAT;
      end else if (softResetBusy) begin
         pinDirection <= `GMPC_RST_BYTE;
         pinState <= `GMPC_RST_BYTE;
         pinIntEnable <= `GMPC_RST_BYTE;
         ctrlBits <= `GMPC_RST_STAT;
      end else if (writeOpen) begin
         case (regAddr)
            `GMPC_ADDR_DIR: begin
               pinDirection <= regWdata;
            end
            `GMPC_ADDR_STATE: begin
               pinState <= regWdata;
            end
            `GMPC_ADDR_INTEN: begin
               pinIntEnable <= regWdata;
            end
            `GMPC_ADDR_CTRL: begin
               // Upper bits are not stored: nothing may hang on them
               if (!regWdata[`GMPC_CTRL_SOFT_RESET_BIT]) begin
                  ctrlBits <= regWdata[`GMPC_CTRL_KEEP_MSB:0];
               end
            end
            default: begin
               pinDirection <= pinDirection;
            end
         endcase
      end
   end

   // Read data is registered; it appears the cycle after the read strobe
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         regRdata <= `GMPC_RST_BYTE;
      end else if (regRead) begin
         case (regAddr)
            `GMPC_ADDR_DIR: begin
               regRdata <= pinDirection;
            end
            `GMPC_ADDR_STATE: begin
               regRdata <= stateView;
            end
            `GMPC_ADDR_INTEN: begin
               regRdata <= pinIntEnable;
            end
            `GMPC_ADDR_CTRL: begin
               regRdata <= ctrlView;
            end
            default: begin
               regRdata <= `GMPC_RST_BYTE;
            end
         endcase
      end
   end

   // Pins leave from flip-flops; the nibble mode decides who owns each pin
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         gpioOut <= `GMPC_RST_BYTE;
         gpioOe <= `GMPC_RST_BYTE;
      end else begin
         gpioOut <= next_gpioOut;
         gpioOe <= next_gpioOe;
      end
   end

   // Modem status, change pulses and modem interrupts of both channels
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         modemStatusA <= `GMPC_RST_STAT;
         modemStatusB <= `GMPC_RST_STAT;
         modemChangeA <= `GMPC_RST_STAT;
         modemChangeB <= `GMPC_RST_STAT;
         modemIrqA <= 1'b0;
         modemIrqB <= 1'b0;
         modemWasA <= 1'b0;
         modemWasB <= 1'b0;
      end else begin
         modemStatusA <= next_statusA;
         modemStatusB <= next_statusB;
         modemChangeA <= next_changeA;
         modemChangeB <= next_changeB;
         modemIrqA <= next_modemIrqA;
         modemIrqB <= next_modemIrqB;
         modemWasA <= modemA;
         modemWasB <= modemB;
      end
   end

   // Pin interrupt and the soft reset level for the rest of the device
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ioIrq <= 1'b0;
         softReset <= 1'b0;
      end else begin
         ioIrq <= next_ioIrq;
         softReset <= softResetBusy;
      end
   end

endmodule // gmpc_pin_control
`default_nettype wire

// file: design/gmpc_soft_reset.v
/*
 * Soft reset sequencer: a start pulse holds a synchronous reset for a fixed
 * number of system clock cycles, then releases it by itself.
 * Assumes one system clock and an asynchronous active-low hardware reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gmpc_defines.vh"

module gmpc_soft_reset (
   input wire clk_sys,
   input wire rst_b,
   input wire start,
   output reg resetActive
);

   localparam [1:0] S_IDLE = 2'b01;
   localparam [1:0] S_HOLD = 2'b10;
   localparam integer HOLD_LAST_INT = `GMPC_SRST_CYCLES - 1;
   localparam [`GMPC_SRST_CNT_W-1:0] HOLD_LAST = HOLD_LAST_INT[`GMPC_SRST_CNT_W-1:0];
   localparam [`GMPC_SRST_CNT_W-1:0] CNT_ZERO = {`GMPC_SRST_CNT_W{1'b0}};
   localparam [`GMPC_SRST_CNT_W-1:0] CNT_ONE = {{(`GMPC_SRST_CNT_W-1){1'b0}}, 1'b1};

   reg [1:0] state;
   reg [`GMPC_SRST_CNT_W-1:0] count;

   // A start while holding is ignored; the reset already covers it
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state <= S_IDLE;
         count <= CNT_ZERO;
         resetActive <= 1'b0;
      end else begin
         case (state)
            S_IDLE: begin
               if (start) begin
                  state <= S_HOLD;
                  count <= CNT_ZERO;
                  resetActive <= 1'b1;
               end
            end
            S_HOLD: begin
               if (count == HOLD_LAST) begin
                  state <= S_IDLE;
                  resetActive <= 1'b0;
               end else begin
                  count <= count + CNT_ONE;
               end
            end
            default: begin
               state <= S_IDLE;
               resetActive <= 1'b0;
            end
         endcase
      end
   end

endmodule // gmpc_soft_reset
`default_nettype wire

// file: testbench/gmpc_pad_model.sv
/* Pads and far-side lines: an external level per pin, overridden by the device drive.
   Assumes the external levels change only just after a clk_sys edge. */
`timescale 1ns/1ps
`default_nettype none
module gmpc_pad_model (
   input wire logic [7:0] gpioOut,
   input wire logic [7:0] gpioOe,
   input wire logic [7:0] extLevel,
   output logic [7:0] gpioIn
);
   // A driven pin shows the device level, else the far side wins
   assign gpioIn = (gpioOe & gpioOut) | (~gpioOe & extLevel);
endmodule // gmpc_pad_model
`default_nettype wire

// file: testbench/gmpc_pin_chk.sv
/* Port checker for the pin function control block.
   Assumes it is bound to gmpc_pin_control, one clk_sys domain reset by rst_b. */
`timescale 1ns/1ps
`default_nettype none
`include "gmpc_defines.vh"
module gmpc_pin_chk (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [`GMPC_ADDR_W-1:0] regAddr,
   input wire logic regWrite,
   input wire logic [7:0] regWdata,
   input wire logic regRead,
   input wire logic [7:0] gpioIn,
   input wire logic [7:0] gpioOut,
   input wire logic [7:0] gpioOe,
   input wire logic mcrTerminalReadyA,
   input wire logic ierModemIntEnableA,
   input wire logic [2:0] modemStatusA,
   input wire logic [2:0] modemChangeA,
   input wire logic modemIrqA,
   input wire logic ioIrq,
   input wire logic softReset
);
   logic modeA;
   logic ctrlWr;
   assign ctrlWr = regWrite && regAddr == `GMPC_ADDR_CTRL;
   // Own copy of the channel A mode bit, so mode checks never trust the design's control register
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) modeA <= 1'b0;
      else if (softReset) modeA <= 1'b0;
      else if (ctrlWr && !regWdata[`GMPC_CTRL_SOFT_RESET_BIT]) modeA <= regWdata[`GMPC_CTRL_MODEM_A];
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   srst_start_a: assert property (
      ctrlWr && regWdata[`GMPC_CTRL_SOFT_RESET_BIT] && !softReset |-> ##2 softReset)
      else $error("soft reset did not start");
   srst_hold_a: assert property ($rose(softReset) |-> softReset [*4] ##1 !softReset)
      else $error("soft reset length wrong");
   srst_quiet_a: assert property (softReset && $past(softReset) |-> !ioIrq)
      else $error("pin interrupt during soft reset");
   io_status_zero_a: assert property (!modeA && !$past(modeA) |-> modemStatusA == 3'h0)
      else $error("modem status shown in plain mode");
   io_no_irq_a: assert property (!modeA && !$past(modeA) |-> !modemIrqA && !(|modemChangeA))
      else $error("modem event in plain mode");
   status_show_a: assert property (
      modeA && $past(modeA) && $past(modeA, 2) && !$past(softReset)
      |-> modemStatusA == ~{$past(gpioIn[6]), $past(gpioIn[7]), $past(gpioIn[4])})
      else $error("modem status does not follow pins");
   dtr_follow_a: assert property (
      modeA && $past(modeA) && !softReset && !$past(softReset)
      |-> gpioOe[5] && gpioOut[5] == !$past(mcrTerminalReadyA))
      else $error("terminal ready pin wrong");
   modem_irq_a: assert property (modemIrqA == (|modemChangeA && $past(ierModemIntEnableA)))
      else $error("modem interrupt mismatch");
   read_clear_a: assert property (
      regRead && regAddr == `GMPC_ADDR_STATE && $stable(gpioIn) ##1 $stable(gpioIn) |=> !ioIrq)
      else $error("state read did not clear interrupt");
   cover property ($rose(softReset));
   cover property (modemIrqA);
   cover property ($rose(ioIrq));
endmodule // gmpc_pin_chk
bind gmpc_pin_control gmpc_pin_chk chk (.clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr),
   .regWrite(regWrite), .regWdata(regWdata), .regRead(regRead), .gpioIn(gpioIn),
   .gpioOut(gpioOut), .gpioOe(gpioOe), .mcrTerminalReadyA(mcrTerminalReadyA),
   .ierModemIntEnableA(ierModemIntEnableA), .modemStatusA(modemStatusA),
   .modemChangeA(modemChangeA), .modemIrqA(modemIrqA), .ioIrq(ioIrq), .softReset(softReset));
`default_nettype wire

// file: testbench/test_gpio_modem_pin_control.sv
/* Directed test of the pin function control block through its register port.
   Assumes the pad model closes the pin loop and the checker is bound. */
`timescale 1ns/1ps
`default_nettype none
`include "gmpc_defines.vh"
module test_gpio_modem_pin_control;
   logic clk_sys, rst_b, regWrite, regRead, mcrA, mcrB, ierA, ierB, irqA, irqB, ioIrq, softReset;
   logic [1:0] regAddr;
   logic [7:0] regWdata, regRdata, gpioIn, gpioOut, gpioOe, extLevel, rdv;
   logic [2:0] statA, statB, chgA, chgB;
   int n_fail = 0;
   int comparisons = 0;
   int n;
   gmpc_pin_control DUT (.clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr),
      .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
      .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe), .mcrTerminalReadyA(mcrA),
      .mcrTerminalReadyB(mcrB), .ierModemIntEnableA(ierA), .ierModemIntEnableB(ierB),
      .modemStatusA(statA), .modemStatusB(statB), .modemChangeA(chgA), .modemChangeB(chgB),
      .modemIrqA(irqA), .modemIrqB(irqB), .ioIrq(ioIrq), .softReset(softReset));
   gmpc_pad_model pads (.gpioOut(gpioOut), .gpioOe(gpioOe), .extLevel(extLevel), .gpioIn(gpioIn));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task tick;
      @(posedge clk_sys);
      #1;
   endtask
   // Each access leaves one idle edge so strobes never toggle twice at once
   task wr(input logic [1:0] a, input logic [7:0] d);
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      tick;
      regWrite = 1'b0;
      tick;
   endtask
   task rd(input logic [1:0] a);
      regAddr = a;
      regRead = 1'b1;
      tick;
      regRead = 1'b0;
      rdv = regRdata;
      tick;
   endtask
   task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task wrap_up;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Whole run is under a hundred cycles; thirty times that means a hang
   initial begin
      repeat (3000) @(posedge clk_sys);
      n_fail++;
      wrap_up;
   end
   initial begin
      {regAddr, regWrite, regRead, regWdata, mcrA, mcrB, ierA, ierB} = '0;
      extLevel = 8'h00;
      rst_b = 1'b0;
      repeat (20) @(posedge clk_sys);
      #1;
      rst_b = 1'b1;
      tick;
      for (int i = 0; i < 4; i++) begin
         rd(i[1:0]);
         chk("reset value", rdv, 8'h00);
      end
      chk("oe reset", gpioOe, 8'h00);
      // Plain I/O drive and readback of mixed directions
      extLevel = 8'h0F;
      wr(`GMPC_ADDR_DIR, 8'hA5);
      wr(`GMPC_ADDR_STATE, 8'h3C);
      chk("oe", gpioOe, 8'hA5);
      chk("out", gpioOut & 8'hA5, 8'h24);
      rd(`GMPC_ADDR_STATE);
      chk("pins", rdv, 8'h2E);
      // Unlatched events on pin 0 only
      extLevel = 8'h00;
      wr(`GMPC_ADDR_DIR, 8'h00);
      wr(`GMPC_ADDR_INTEN, 8'h01);
      rd(`GMPC_ADDR_STATE);
      extLevel = 8'h02;
      tick;
      tick;
      chk("unarmed irq", {7'h0, ioIrq}, 8'h00);
      extLevel = 8'h03;
      tick;
      chk("irq raised", {7'h0, ioIrq}, 8'h01);
      extLevel = 8'h02;
      tick;
      tick;
      chk("irq withdrawn", {7'h0, ioIrq}, 8'h00);
      extLevel = 8'h03;
      tick;
      tick;
      rd(`GMPC_ADDR_STATE);
      chk("live state", rdv, 8'h03);
      chk("irq read clear", {7'h0, ioIrq}, 8'h00);
      // Latched: a pulse on pin 0 keeps the captured level
      wr(`GMPC_ADDR_CTRL, 8'h01);
      rd(`GMPC_ADDR_STATE);
      extLevel = 8'h02;
      tick;
      tick;
      extLevel = 8'h03;
      tick;
      tick;
      chk("latched irq", {7'h0, ioIrq}, 8'h01);
      rd(`GMPC_ADDR_STATE);
      chk("captured", rdv, 8'h02);
      chk("latched clear", {7'h0, ioIrq}, 8'h00);
      // Both nibbles as modem lines while the I/O registers say otherwise
      extLevel = 8'hFF;
      wr(`GMPC_ADDR_CTRL, 8'h06);
      wr(`GMPC_ADDR_INTEN, 8'hFF);
      mcrA = 1'b1;
      ierA = 1'b1;
      tick;
      tick;
      chk("oe modem", gpioOe, 8'h22);
      chk("dtr", gpioOut & 8'h22, 8'h02);
      extLevel = 8'hB7;
      tick;
      chk("status A", {5'h0, statA}, 8'h04);
      chk("change A", {5'h0, chgA}, 8'h04);
      chk("irq A", {7'h0, irqA}, 8'h01);
      chk("status B", {5'h0, statB}, 8'h02);
      chk("change B", {5'h0, chgB}, 8'h02);
      chk("irq B off", {7'h0, irqB}, 8'h00);
      tick;
      chk("no pin irq", {7'h0, ioIrq}, 8'h00);
      ierB = 1'b1;
      extLevel = 8'hFF;
      tick;
      chk("irq B", {7'h0, irqB}, 8'h01);
      // Back to plain I/O: modem side goes silent
      wr(`GMPC_ADDR_CTRL, 8'h00);
      rd(`GMPC_ADDR_STATE);
      tick;
      chk("dtr ignored", gpioOe, 8'h00);
      chk("dtr pin", gpioOut & 8'h22, 8'h20);
      extLevel = 8'hBF;
      tick;
      chk("status quiet", {5'h0, statA}, 8'h00);
      chk("change quiet", {4'h0, irqA, chgA}, 8'h00);
      chk("B quiet", {irqB, 1'b0, chgB, statB}, 8'h00);
      tick;
      chk("io irq", {7'h0, ioIrq}, 8'h01);
      // Soft reset clears the registers and itself
      wr(`GMPC_ADDR_DIR, 8'h5A);
      regAddr = `GMPC_ADDR_CTRL;
      regWdata = 8'h0F;
      regWrite = 1'b1;
      tick;
      regWrite = 1'b0;
      tick;
      chk("soft reset", {7'h0, softReset}, 8'h01);
      n = 0;
      repeat (8) begin
         if (softReset === 1'b1) n++;
         tick;
      end
      chk("reset length", n[7:0], 8'h04);
      rd(`GMPC_ADDR_CTRL);
      chk("ctrl cleared", rdv, 8'h00);
      rd(`GMPC_ADDR_DIR);
      chk("dir cleared", rdv, 8'h00);
      chk("oe cleared", gpioOe, 8'h00);
      wrap_up;
   end
endmodule // test_gpio_modem_pin_control
`default_nettype wire
